// ==== common/clu_pkg.sv ====
// constants shared by the configurable lookup-table logic unit
package clu_pkg;
	localparam int NUM_TABLES = 4;
	localparam int NUM_PAIRS  = 2;
	// register word indices, byte address is four times the index
	localparam logic [4:0] IDX_CTRL       = 5'h00;
	localparam logic [4:0] IDX_SEQ0       = 5'h01;
	localparam logic [4:0] IDX_SEQ1       = 5'h02;
	localparam logic [4:0] IDX_TABLE_BASE = 5'h08;
	localparam logic [4:0] IDX_TABLE_LAST = 5'h17;
	// register within one table group
	localparam logic [1:0] SUB_CTRLA = 2'h0;
	localparam logic [1:0] SUB_CTRLB = 2'h1;
	localparam logic [1:0] SUB_CTRLC = 2'h2;
	localparam logic [1:0] SUB_TRUTH = 2'h3;
	// field positions
	localparam int GLOB_EN_BIT = 0;
	localparam int CA_EN_BIT   = 0;
	localparam int CA_CLK_LSB  = 1;
	localparam int CA_FILT_LSB = 4;
	localparam int CA_OUTEN    = 6;
	localparam int CA_EDGE     = 7;
	localparam int CB_IN0_LSB  = 0;
	localparam int CB_IN1_LSB  = 4;
	localparam int CC_IN2_LSB  = 0;
	// reset value of every register
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// input source codes
	localparam logic [3:0] SRC_OFF      = 4'h0;
	localparam logic [3:0] SRC_FEEDBACK = 4'h1;
	localparam logic [3:0] SRC_LINK     = 4'h2;
	localparam logic [3:0] SRC_EVENT_A  = 4'h3;
	localparam logic [3:0] SRC_EVENT_B  = 4'h4;
	localparam logic [3:0] SRC_PIN      = 4'h5;
	localparam logic [3:0] SRC_CMP      = 4'h6;
	localparam logic [3:0] SRC_UART     = 4'h8;
	localparam logic [3:0] SRC_SPI      = 4'h9;
	localparam logic [3:0] SRC_TIMER_A  = 4'ha;
	localparam logic [3:0] SRC_TIMER_B  = 4'hc;
	// output filter codes
	localparam logic [1:0] FILT_NONE = 2'h0;
	localparam logic [1:0] FILT_SYNC = 2'h1;
	localparam logic [1:0] FILT_GLITCH = 2'h2;
	// clock source code for the table local clock
	localparam logic [2:0] CLK_LOCAL = 3'h1;
	// pair function codes
	localparam logic [3:0] SEQ_OFF   = 4'h0;
	localparam logic [3:0] SEQ_DFF   = 4'h1;
	localparam logic [3:0] SEQ_JK    = 4'h2;
	localparam logic [3:0] SEQ_LATCH = 4'h3;
	localparam logic [3:0] SEQ_RS    = 4'h4;
endpackage

// ==== design/table_output_stage.sv ====
// resynchroniser, glitch filter and rising edge detector of one table
`timescale 1ns/1ps
module table_output_stage (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// table clock edge and clear one cycle after disable
	input  wire logic       tick_i,
	input  wire logic       clear_i,
	// configuration
	input  wire logic [1:0] mode_i,
	input  wire logic       edge_i,
	// table value in, staged value out
	input  wire logic       value_i,
	output logic            stage_o
);
	logic [2:0] hist;
	logic       held;
	logic       prev;
	logic       filt;

	// sample history on each table clock edge
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			hist <= 3'h0;
		end else if (tick_i) begin
			hist <= {hist[1:0], value_i};
		end
	end

	// pass a value only once three samples agree
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			held <= 1'b0;
		end else if (tick_i && hist[0] == hist[1] && hist[1] == hist[2]) begin
			held <= hist[2];
		end
	end

	// edge detector memory
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			prev <= 1'b0;
		end else if (tick_i) begin
			prev <= filt;
		end
	end

	// option select and edge pulse
	always_comb begin
		case (mode_i)
			clu_pkg::FILT_SYNC:   filt = hist[1];
			clu_pkg::FILT_GLITCH: filt = held;
			default:              filt = value_i;
		endcase
		stage_o = edge_i ? (filt & ~prev) : filt;
	end
endmodule

// ==== design/pair_state_element.sv ====
// flip-flop or latch fed by one even/odd table pair
`timescale 1ns/1ps
module pair_state_element (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// even table clock edge, pair clear
	input  wire logic       tick_i,
	input  wire logic       clear_i,
	// function and data
	input  wire logic [3:0] mode_i,
	input  wire logic       even_i,
	input  wire logic       odd_i,
	output logic            out_o
);
	logic q;
	logic next_q;

	// next state per function
	always_comb begin
		next_q = q;
		case (mode_i)
			clu_pkg::SEQ_DFF: begin
				if (tick_i && odd_i) begin
					next_q = even_i;
				end
			end
			clu_pkg::SEQ_JK: begin
				if (tick_i) begin
					case ({even_i, odd_i})
						2'b01:   next_q = 1'b0;
						2'b10:   next_q = 1'b1;
						2'b11:   next_q = ~q;
						default: next_q = q;
					endcase
				end
			end
			clu_pkg::SEQ_LATCH: begin
				if (odd_i) begin
					next_q = even_i;
				end
			end
			clu_pkg::SEQ_RS: begin
				if (even_i && !odd_i) begin
					next_q = 1'b1;
				end else if (odd_i && !even_i) begin
					next_q = 1'b0;
				end
			end
			default: next_q = 1'b0;
		endcase
	end

	// state register, flip-flops move only on table clock edges
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			q <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	// latches are transparent, clear forces low at once
	always_comb begin
		if (clear_i) begin
			out_o = 1'b0;
		end else if (mode_i == clu_pkg::SEQ_LATCH || mode_i == clu_pkg::SEQ_RS) begin
			out_o = next_q;
		end else begin
			out_o = q;
		end
	end
endmodule

// ==== design/custom_logic_unit.sv ====
// four-table configurable logic unit with wishbone register access
`timescale 1ns/1ps
module custom_logic_unit #(
	parameter int ADR_W = 8
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// table input pins, bit 3*n+y is table n input y
	input  wire logic [11:0] table_pin_i,
	// event inputs, one per table
	input  wire logic [3:0]  event_a_i,
	input  wire logic [3:0]  event_b_i,
	// on-chip peripheral sources, one per input position except the comparator, shared by all
	input  wire logic        cmp_out_i,
	input  wire logic [2:0]  uart_txd_i,
	input  wire logic [2:0]  spi_line_i,
	input  wire logic [2:0]  timer_a_wo_i,
	input  wire logic [2:0]  timer_b_wo_i,
	// outputs
	output logic      [3:0]  table_out_o,
	output logic      [3:0]  table_out_en_o,
	output logic      [1:0]  sequencer_out_o
);
	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	// the word index sits in address bits 6 down to 2
	if (ADR_W < 7) begin : g_chk
		$error("address bus too narrow for the register map");
	end

	// ----------------------------------------------------------------
	// configuration storage
	// ----------------------------------------------------------------
	logic       glob_en;
	logic [3:0] seq_sel [clu_pkg::NUM_PAIRS];
	logic [3:0] t_en;
	logic [3:0] edge_en;
	logic [3:0] out_en;
	logic [1:0] filt [clu_pkg::NUM_TABLES];
	logic [2:0] clock_source_select [clu_pkg::NUM_TABLES];
	logic [3:0] insel [clu_pkg::NUM_TABLES][3];
	logic [7:0] truth [clu_pkg::NUM_TABLES];

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic [4:0] idx;
	logic [4:0] rel;
	logic [1:0] tn;
	logic [1:0] sub;
	logic       req;
	logic       wr;
	logic       is_tbl;
	logic       prot_ok;
	logic [7:0] rdata;

	// word index, table number and register within the table
	// ack masks req, so a request held over two edges is taken only once;
	// a write lands at the edge that takes it, one edge before ack is seen
	// protection reads the stored enable of the pair's even table before
	// this write, so the write that sets enable may carry fields and the
	// write that clears it may not
	assign idx     = wb_adr_i[6:2];
	assign rel     = idx - clu_pkg::IDX_TABLE_BASE;
	assign tn      = rel[3:2];
	assign sub     = rel[1:0];
	assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr      = req & wb_we_i & wb_sel_i[0];
	assign is_tbl  = (idx >= clu_pkg::IDX_TABLE_BASE) && (idx <= clu_pkg::IDX_TABLE_LAST);
	assign prot_ok = ~t_en[{tn[1], 1'b0}];

	// global enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			glob_en <= 1'b0;
		end else if (wr && idx == clu_pkg::IDX_CTRL) begin
			glob_en <= wb_dat_i[clu_pkg::GLOB_EN_BIT];
		end
	end

	// pair function select, guarded by the even table enable
	// one index per cycle, so the else-if chain never drops a write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			seq_sel[0] <= clu_pkg::RESET_BYTE[3:0];
			seq_sel[1] <= clu_pkg::RESET_BYTE[3:0];
		end else if (wr && idx == clu_pkg::IDX_SEQ0 && !t_en[0]) begin
			seq_sel[0] <= wb_dat_i[3:0];
		end else if (wr && idx == clu_pkg::IDX_SEQ1 && !t_en[2]) begin
			seq_sel[1] <= wb_dat_i[3:0];
		end
	end

	// control a: enable always, other fields only while unprotected
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t_en    <= clu_pkg::RESET_BYTE[3:0];
			edge_en <= clu_pkg::RESET_BYTE[3:0];
			out_en  <= clu_pkg::RESET_BYTE[3:0];
			for (int i = 0; i < clu_pkg::NUM_TABLES; i++) begin
				filt[i]   <= clu_pkg::RESET_BYTE[1:0];
				clock_source_select[i] <= clu_pkg::RESET_BYTE[2:0];
			end
		end else if (wr && is_tbl && sub == clu_pkg::SUB_CTRLA) begin
			t_en[tn] <= wb_dat_i[clu_pkg::CA_EN_BIT];
			if (prot_ok) begin
				edge_en[tn] <= wb_dat_i[clu_pkg::CA_EDGE];
				out_en[tn]  <= wb_dat_i[clu_pkg::CA_OUTEN];
				filt[tn]    <= wb_dat_i[clu_pkg::CA_FILT_LSB +: 2];
				clock_source_select[tn]  <= wb_dat_i[clu_pkg::CA_CLK_LSB +: 3];
			end
		end
	end

	// input source selects
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < clu_pkg::NUM_TABLES; i++) begin
				for (int y = 0; y < 3; y++) begin
					insel[i][y] <= clu_pkg::RESET_BYTE[3:0];
				end
			end
		end else if (wr && is_tbl && prot_ok) begin
			if (sub == clu_pkg::SUB_CTRLB) begin
				insel[tn][0] <= wb_dat_i[clu_pkg::CB_IN0_LSB +: 4];
				insel[tn][1] <= wb_dat_i[clu_pkg::CB_IN1_LSB +: 4];
			end else if (sub == clu_pkg::SUB_CTRLC) begin
				insel[tn][2] <= wb_dat_i[clu_pkg::CC_IN2_LSB +: 4];
			end
		end
	end

	// table values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < clu_pkg::NUM_TABLES; i++) begin
				truth[i] <= clu_pkg::RESET_BYTE;
			end
		end else if (wr && is_tbl && sub == clu_pkg::SUB_TRUTH) begin
			truth[tn] <= wb_dat_i[7:0];
		end
	end

	// read multiplexer, unmapped words read zero
	// stored values come back, so a refused field reads as the value in force
	always_comb begin
		rdata = 8'h00;
		if (idx == clu_pkg::IDX_CTRL) begin
			rdata[clu_pkg::GLOB_EN_BIT] = glob_en;
		end else if (idx == clu_pkg::IDX_SEQ0) begin
			rdata[3:0] = seq_sel[0];
		end else if (idx == clu_pkg::IDX_SEQ1) begin
			rdata[3:0] = seq_sel[1];
		end else if (is_tbl) begin
			case (sub)
				clu_pkg::SUB_CTRLA: rdata = {edge_en[tn], out_en[tn], filt[tn],
					clock_source_select[tn], t_en[tn]};
				clu_pkg::SUB_CTRLB: rdata = {insel[tn][1], insel[tn][0]};
				clu_pkg::SUB_CTRLC: rdata = {4'h0, insel[tn][2]};
				default:            rdata = truth[tn];
			endcase
		end
	end

	// single-wait-state acknowledge with registered read data
	// ack falls by itself after one cycle, before the master drops the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			if (req) begin
				wb_dat_o <= {24'h0, rdata};
			end
		end
	end

	// ----------------------------------------------------------------
	// table datapath
	// ----------------------------------------------------------------
	logic [11:0] pin_m;
	logic [11:0] pin_s;
	logic [3:0]  act;
	logic [3:0]  dis_q;
	logic [3:0]  tick;
	logic [3:0]  raw;
	logic [3:0]  staged;
	logic [3:0]  lclk_prev;
	logic [1:0]  seq_out;

	// source selection for one table input
	// off and reserved codes fall to the default and read low
	function automatic logic pick(input logic [3:0] code, input logic fb, input logic lk,
		input logic ea, input logic eb, input logic pin, input logic cmp,
		input logic ua, input logic sp, input logic ta, input logic tb);
		case (code)
			clu_pkg::SRC_FEEDBACK: pick = fb;
			clu_pkg::SRC_LINK:     pick = lk;
			clu_pkg::SRC_EVENT_A:  pick = ea;
			clu_pkg::SRC_EVENT_B:  pick = eb;
			clu_pkg::SRC_PIN:      pick = pin;
			clu_pkg::SRC_CMP:      pick = cmp;
			clu_pkg::SRC_UART:     pick = ua;
			clu_pkg::SRC_SPI:      pick = sp;
			clu_pkg::SRC_TIMER_A:  pick = ta;
			clu_pkg::SRC_TIMER_B:  pick = tb;
			default:               pick = 1'b0;
		endcase
	endfunction

	// pins come from outside, two flops before use
	// pins therefore lag events and peripheral lines by two cycles
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_m <= 12'h000;
			pin_s <= 12'h000;
		end else begin
			pin_m <= table_pin_i;
			pin_s <= pin_m;
		end
	end

	// active tables and the delayed disable that clears stage state
	// dis_q resets high so stage state stays clear until a table is enabled
	assign act = {4{glob_en}} & t_en;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dis_q <= 4'hf;
		end else begin
			dis_q <= ~act;
		end
	end

	// one lookup per table; link and feedback close loops only if software asks
	for (genvar n = 0; n < clu_pkg::NUM_TABLES; n++) begin : g_tbl
		logic [2:0] src;
		logic [2:0] sel_idx;
		logic       local_clk;

		for (genvar y = 0; y < 3; y++) begin : g_in
			assign src[y] = pick(insel[n][y], seq_out[n/2],
				raw[(n + 1) % clu_pkg::NUM_TABLES], event_a_i[n], event_b_i[n],
				pin_s[3*n+y], cmp_out_i, uart_txd_i[y], spi_line_i[y],
				timer_a_wo_i[y], timer_b_wo_i[y]);
		end

		// local clock edge from input 2, else every system clock
		// input 2 is sampled on the system clock: a local clock must stay well
		// below half of it, or its rises are missed
		assign local_clk = (clock_source_select[n] == clu_pkg::CLK_LOCAL);
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				lclk_prev[n] <= 1'b0;
			end else begin
				lclk_prev[n] <= src[2];
			end
		end
		assign tick[n] = local_clk ? (src[2] & ~lclk_prev[n]) : 1'b1;

		// lookup, input 2 reads low when it is the clock
		assign sel_idx = {src[2] & ~local_clk, src[1], src[0]};
		assign raw[n]  = act[n] & truth[n][sel_idx];

		table_output_stage u_stage (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.tick_i  (tick[n]),
			.clear_i (dis_q[n]),
			.mode_i  (filt[n]),
			.edge_i  (edge_en[n]),
			.value_i (raw[n]),
			.stage_o (staged[n])
		);
	end

	// one state element per pair, clocked and cleared by its even table
	for (genvar p = 0; p < clu_pkg::NUM_PAIRS; p++) begin : g_pair
		pair_state_element u_seq (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.tick_i  (tick[2*p]),
			.clear_i (~act[2*p] | dis_q[2*p]),
			.mode_i  (seq_sel[p]),
			.even_i  (staged[2*p]),
			.odd_i   (staged[2*p+1]),
			.out_o   (seq_out[p])
		);
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	// table outputs and output enables gated by active, so a table or unit switched off reads low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			table_out_o     <= 4'h0;
			table_out_en_o  <= 4'h0;
			sequencer_out_o <= 2'h0;
		end else begin
			table_out_o     <= act & staged;
			table_out_en_o  <= act & out_en;
			sequencer_out_o <= seq_out;
		end
	end
endmodule

// ==== bench/custom_logic_unit_monitor.sv ====
// port assertions for the configurable lookup-table logic unit
`timescale 1ns/1ps
module custom_logic_unit_monitor #(
	parameter int ADR_W = 8
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	input  wire logic [31:0]      wb_dat_o,
	input  wire logic             wb_ack_o,
	// sources
	input  wire logic [11:0]      table_pin_i,
	input  wire logic [3:0]       event_a_i,
	input  wire logic [3:0]       event_b_i,
	input  wire logic             cmp_out_i,
	input  wire logic [2:0]       uart_txd_i,
	input  wire logic [2:0]       spi_line_i,
	input  wire logic [2:0]       timer_a_wo_i,
	input  wire logic [2:0]       timer_b_wo_i,
	// outputs
	input  wire logic [3:0]       table_out_o,
	input  wire logic [3:0]       table_out_en_o,
	input  wire logic [1:0]       sequencer_out_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// -------------------------------------------------------------
	// request decode
	// -------------------------------------------------------------
	// a request is taken, a byte write with bit 0 low is taken
	logic take;
	logic wr_lo;
	assign take  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_lo = take && wb_we_i && wb_sel_i[0] && !wb_dat_i[0];

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	property p_ack_answer; take |=> wb_ack_o; endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
	property p_ack_cause; wb_ack_o |-> $past(take); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits set");
	property p_dat_hold; !wb_ack_o |-> $stable(wb_dat_o); endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
	property p_glob_off;
		wr_lo && wb_adr_i[6:2] == 5'h00 |-> ##2 (table_out_o == 4'h0 && table_out_en_o == 4'h0);
	endproperty
	a_glob_off: assert property (p_glob_off) else $error("unit off, outputs live");
	property p_table_off;
		wr_lo && wb_adr_i[6:2] == 5'h08 |-> ##2 (!table_out_o[0] && !table_out_en_o[0]);
	endproperty
	a_table_off: assert property (p_table_off) else $error("table 0 off, output live");
	property p_odd_off; wr_lo && wb_adr_i[6:2] == 5'h0c |-> ##2 !table_out_o[1]; endproperty
	a_odd_off: assert property (p_odd_off) else $error("table 1 off, output live");
	property p_pair_clear;
		wr_lo && wb_adr_i[6:2] == 5'h08 |-> ##2 !sequencer_out_o[0] [*2];
	endproperty
	a_pair_clear: assert property (p_pair_clear) else $error("pair 0 not cleared");
endmodule

// ==== bench/source_model.sv ====
// far-side sources: pins, events and peripheral lines
`timescale 1ns/1ps
module source_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// levels asked for by the bench
	input  wire logic [32:0] want_i,
	// lines into the unit
	output logic      [11:0] pin_o,
	output logic      [3:0]  ev_a_o,
	output logic      [3:0]  ev_b_o,
	output logic             cmp_o,
	output logic      [2:0]  uart_o,
	output logic      [2:0]  spi_o,
	output logic      [2:0]  tca_o,
	output logic      [2:0]  tcb_o
);
	// levels move just after an edge, like any clocked source
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{tcb_o, tca_o, spi_o, uart_o, cmp_o, ev_b_o, ev_a_o, pin_o} <= 33'h0;
		end else begin
			{tcb_o, tca_o, spi_o, uart_o, cmp_o, ev_b_o, ev_a_o, pin_o} <= want_i;
		end
	end
endmodule

// ==== bench/custom_logic_unit_tb_top.sv ====
// self-checking bench for the configurable lookup-table logic unit
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module custom_logic_unit_tb_top;
	logic        clk_i, rst_i, cyc, stb, we, ack;
	logic [7:0]  adr, tv;
	logic [31:0] dw, dr, rd;
	logic [11:0] pins, pl;
	logic [3:0]  eva, evb, ea, eb, tout, ten;
	logic [12:0] per;
	logic        cmp;
	logic [2:0]  ua, sp, ta, tb;
	logic [1:0]  sq;
	logic [6:0]  st [12];
	int          n_fail, n_checks, cyc_cnt, i, k, n0, n1;

	// -------------------------------------------------------------
	// clock, timeout, verdict
	// -------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic stop_test();
		if (n_fail == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			$display("wrong value at %0t: run timed out", $time);
			n_fail++;
			stop_test();
		end
	end

	// -------------------------------------------------------------
	// design, sources, checker
	// -------------------------------------------------------------
	source_model src (.clk_i(clk_i), .rst_i(rst_i), .want_i({per, evb, eva, pins}),
		.pin_o(pl), .ev_a_o(ea), .ev_b_o(eb), .cmp_o(cmp), .uart_o(ua), .spi_o(sp),
		.tca_o(ta), .tcb_o(tb));
	custom_logic_unit #(.ADR_W(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dw),
		.wb_dat_o(dr), .wb_ack_o(ack), .table_pin_i(pl), .event_a_i(ea), .event_b_i(eb),
		.cmp_out_i(cmp), .uart_txd_i(ua), .spi_line_i(sp), .timer_a_wo_i(ta),
		.timer_b_wo_i(tb), .table_out_o(tout), .table_out_en_o(ten), .sequencer_out_o(sq));

	// -------------------------------------------------------------
	// bus tasks
	// -------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic xfer(input logic [4:0] idx, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {1'b0, idx, 2'b00};
		dw <= {24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] idx, input logic [7:0] d);
		xfer(idx, 1'b1, d);
	endtask
	task automatic rchk(input logic [4:0] idx, input logic [7:0] e);
		xfer(idx, 1'b0, 8'h00);
		`CHK(rd, {24'h0, e})
	endtask
	function automatic logic [4:0] ti(input int n, input int s);
		return 5'(8 + 4 * n + s);
	endfunction
	// program one table while it is off, enable last
	task automatic cfg(input int n, input logic [7:0] a, b, c, t);
		wr(ti(n, 0), 8'h00);
		wr(ti(n, 1), b);
		wr(ti(n, 2), c);
		wr(ti(n, 3), t);
		wr(ti(n, 0), a);
	endtask
	// cycles from an event rise to the table 0 output rise
	task automatic meas(input logic [7:0] a, output int n);
		cfg(0, a, {4'h0, clu_pkg::SRC_EVENT_A}, 8'h00, 8'haa);
		eva[0] <= 1'b0;
		tick(8);
		eva[0] <= 1'b1;
		n = 0;
		while (tout[0] !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
	endtask
	task automatic count_high(input int n);
		k = 0;
		repeat (n) begin
			tick(1);
			if (tout[0] === 1'b1) k++;
		end
	endtask

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		{cyc, stb, we, adr, dw, pins, eva, evb, per} = '0;
		{n_fail, n_checks} = '0;
		st = '{7'h0f, 7'h09, 7'h0a, 7'h15, 7'h11, 7'h12, 7'h1f, 7'h19, 7'h1a, 7'h25,
			7'h21, 7'h22};
		rst_i = 1'b1;
		tick(6);
		rst_i <= 1'b0;
		// reset values, unmapped place
		for (i = 0; i < 24; i++) rchk(5'(i), 8'h00);
		wr(5'h03, 8'hff);
		rchk(5'h03, 8'h00);
		// enable protection
		wr(5'h00, 8'h01);
		wr(ti(0, 0), 8'h41);
		rchk(ti(0, 0), 8'h41);
		`CHK(ten, 4'h1)
		wr(ti(0, 1), 8'h55);
		wr(ti(1, 1), 8'h55);
		wr(5'h01, 8'h01);
		rchk(ti(0, 1), 8'h00);
		rchk(ti(1, 1), 8'h00);
		rchk(5'h01, 8'h00);
		wr(ti(0, 0), 8'h70);
		rchk(ti(0, 0), 8'h40);
		// lookup over all eight indices
		tv = 8'hb4;
		cfg(0, 8'h01, {clu_pkg::SRC_EVENT_B, clu_pkg::SRC_EVENT_A}, {4'h0, clu_pkg::SRC_CMP}, tv);
		for (i = 0; i < 8; i++) begin
			eva[0] <= i[0];
			evb[0] <= i[1];
			per[0] <= i[2];
			tick(3);
			`CHK(tout[0], tv[i])
		end
		// off and reserved sources read low
		cfg(0, 8'h01, 8'h00, 8'h07, 8'hfe);
		tick(3);
		`CHK(tout[0], 1'b0)
		// pin source, then link from table 0 into table 3
		cfg(0, 8'h01, {4'h0, clu_pkg::SRC_PIN}, 8'h00, 8'haa);
		pins <= 12'h001;
		tick(6);
		`CHK(tout[0], 1'b1)
		cfg(3, 8'h01, {4'h0, clu_pkg::SRC_LINK}, 8'h00, 8'haa);
		pins <= 12'hffe;
		tick(8);
		`CHK(tout, 4'h0)
		pins <= 12'h001;
		tick(8);
		`CHK(tout[3], 1'b1)
		// resync and filter delays, glitch blocked
		meas(8'h01, n0);
		meas(8'h11, n1);
		`CHK(n1 - n0, 2)
		meas(8'h21, n1);
		`CHK(n1 - n0, 4)
		eva[0] <= 1'b0;
		tick(10);
		eva[0] <= 1'b1;
		tick(1);
		eva[0] <= 1'b0;
		count_high(10);
		`CHK(k, 0)
		// edge pulse with resync, cleared state after disable
		wr(ti(0, 0), 8'h00);
		wr(ti(0, 0), 8'h91);
		eva[0] <= 1'b1;
		count_high(12);
		`CHK(k, 1)
		wr(ti(0, 0), 8'h90);
		tick(3);
		wr(ti(0, 0), 8'h91);
		count_high(12);
		`CHK(k, 1)
		// pair functions: even from event 0, odd from event 1
		wr(ti(0, 0), 8'h00);
		cfg(1, 8'h01, {4'h0, clu_pkg::SRC_EVENT_A}, 8'h00, 8'haa);
		for (i = 0; i < 12; i++) begin
			if (i % 3 == 0) begin
				wr(ti(0, 0), 8'h00);
				wr(5'h01, {4'h0, st[i][6:3]});
				wr(ti(0, 0), 8'h01);
			end
			eva[1:0] <= {st[i][1], st[i][2]};
			tick(5);
			`CHK(sq, {1'b0, st[i][0]})
		end
		// local clock from input 2: stages move on its rises, input 2 reads low
		evb[0] <= 1'b0;
		cfg(0, 8'h13, {4'h0, clu_pkg::SRC_EVENT_A}, {4'h0, clu_pkg::SRC_EVENT_B}, 8'h02);
		eva[0] <= 1'b1;
		tick(8);
		`CHK(tout[0], 1'b0)
		for (i = 0; i < 2; i++) begin
			evb[0] <= 1'b1;
			tick(2);
			evb[0] <= 1'b0;
			tick(2);
		end
		`CHK(tout[0], 1'b1)
		// global disable, then a reset in mid-run
		wr(5'h00, 8'h00);
		tick(3);
		`CHK(tout, 4'h0)
		rst_i <= 1'b1;
		tick(6);
		rst_i <= 1'b0;
		rchk(ti(0, 0), 8'h00);
		stop_test();
	end
endmodule

bind custom_logic_unit custom_logic_unit_monitor #(.ADR_W(ADR_W)) u_mon (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .table_pin_i(table_pin_i), .event_a_i(event_a_i),
	.event_b_i(event_b_i), .cmp_out_i(cmp_out_i), .uart_txd_i(uart_txd_i),
	.spi_line_i(spi_line_i), .timer_a_wo_i(timer_a_wo_i), .timer_b_wo_i(timer_b_wo_i),
	.table_out_o(table_out_o), .table_out_en_o(table_out_en_o),
	.sequencer_out_o(sequencer_out_o));
